// ==== pkg/ctf_pkg.sv ====
// Constants, register map and field layout of the cascadable compare timer
package ctf_pkg;

  // Register addresses
  localparam logic [15:0] ADDR_CTRL     = 16'hFFB6;
  localparam logic [15:0] ADDR_STAT     = 16'hFFB7;
  localparam logic [15:0] ADDR_CNT_HI   = 16'hFFB8;
  localparam logic [15:0] ADDR_CNT_LO   = 16'hFFB9;
  localparam logic [15:0] ADDR_CMP_HI   = 16'hFFBA;
  localparam logic [15:0] ADDR_CMP_LO   = 16'hFFBB;
  localparam logic [15:0] ADDR_CLK_STOP = 16'hFFFA;
  localparam logic [15:0] ADDR_IRQ_REQ  = 16'hFFC0;
  localparam logic [15:0] ADDR_IRQ_EN   = 16'hFFC1;

  // Reset values, fixed read values and the all-ones byte
  localparam logic [7:0] RST_CTRL     = 8'h00;
  localparam logic [7:0] RST_STAT     = 8'h00;
  localparam logic [7:0] RST_CNT      = 8'h00;
  localparam logic [7:0] RST_CMP      = 8'hFF;
  localparam logic [7:0] RST_CLK_STOP = 8'hFF;
  localparam logic [7:0] RD_WRITE_ONLY = 8'hFF;
  localparam logic [7:0] RD_UNMAPPED  = 8'h00;
  localparam logic [7:0] BYTE_ONES    = 8'hFF;

  // Control register fields
  localparam int CTRL_TOGGLE_HI = 7;
  localparam int CTRL_SEL_HI_MSB = 6;
  localparam int CTRL_SEL_HI_LSB = 4;
  localparam int CTRL_TOGGLE_LO = 3;
  localparam int CTRL_SEL_LO_MSB = 2;
  localparam int CTRL_SEL_LO_LSB = 0;

  // Status register fields
  localparam int STAT_OVF_HI  = 7;
  localparam int STAT_CMF_HI  = 6;
  localparam int STAT_OVIE_HI = 5;
  localparam int STAT_CCLR_HI = 4;
  localparam int STAT_OVF_LO  = 3;
  localparam int STAT_CMF_LO  = 2;
  localparam int STAT_OVIE_LO = 1;
  localparam int STAT_CCLR_LO = 0;

  // Request and enable register fields, clock stop bit
  localparam int IRQ_BIT_HI    = 1;
  localparam int IRQ_BIT_LO    = 0;
  localparam int CLK_STOP_BIT  = 2;

  // Clock select encodings
  localparam logic [2:0] SEL_CASCADE = 3'h0;
  localparam logic [2:0] SEL_EVENT   = 3'h0;
  localparam logic [2:0] SEL_DIV32   = 3'h4;
  localparam logic [2:0] SEL_DIV16   = 3'h5;
  localparam logic [2:0] SEL_DIV4    = 3'h6;
  localparam logic [2:0] SEL_SUB4    = 3'h7;

  // Prescaler
  localparam int PRE_WIDTH = 5;
  localparam logic [4:0] PRE_MASK32 = 5'h1F;
  localparam logic [4:0] PRE_MASK16 = 5'h0F;
  localparam logic [4:0] PRE_MASK4  = 5'h03;
  localparam logic [1:0] SUB_LAST   = 2'h3;

endpackage

// ==== verilog/ctf_prescaler.sv ====
// Divided count ticks from the system clock and the subclock
module ctf_prescaler
  import ctf_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Subclock level, sampled on clk
  input  wire logic sub_clk,
  // One-cycle ticks
  output logic      tick_div32,
  output logic      tick_div16,
  output logic      tick_div4,
  output logic      tick_sub4
);

  logic [PRE_WIDTH-1:0] pre_ff;
  logic [1:0]           sub_cnt_ff;
  logic                 sub_prev_ff;
  logic                 sub_rise;

  assign sub_rise = sub_clk & ~sub_prev_ff;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_ff <= '0;
    end else begin
      pre_ff <= pre_ff + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sub_prev_ff <= 1'b0;
      sub_cnt_ff  <= '0;
    end else begin
      sub_prev_ff <= sub_clk;
      if (sub_rise) begin
        sub_cnt_ff <= sub_cnt_ff + 1'b1;
      end
    end
  end

  assign tick_div32 = (pre_ff & PRE_MASK32) == PRE_MASK32;
  assign tick_div16 = (pre_ff & PRE_MASK16) == PRE_MASK16;
  assign tick_div4  = (pre_ff & PRE_MASK4) == PRE_MASK4;
  assign tick_sub4  = sub_rise && (sub_cnt_ff == SUB_LAST);

endmodule

// ==== verilog/ctf_event_edge.sv ====
// Edge detector for the external event input
module ctf_event_edge
  import ctf_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Event pin and edge choice, 1 selects rising
  input  wire logic event_input_pin,
  input  wire logic edge_rising,
  // One-cycle event tick
  output logic      event_tick
);

  logic prev_ff;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= event_input_pin;
    end
  end

  assign event_tick = edge_rising ? (event_input_pin & ~prev_ff)
                                  : (~event_input_pin & prev_ff);

endmodule

// ==== verilog/ctf_timer.sv ====
// Cascadable 16-bit / dual 8-bit compare timer with register port
//
// Implementation choice: the address-and-strobe port.
module ctf_timer
  import ctf_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Register port
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  // Clock sources and power state
  input  wire logic        sub_clk,
  input  wire logic        low_power_mode,
  // External event
  input  wire logic        event_input_pin,
  input  wire logic        event_edge_rising,
  // Toggle outputs
  output logic             upper_toggle_pin,
  output logic             lower_toggle_pin,
  // Interrupts to the CPU
  output logic             irq_upper,
  output logic             irq_lower
);

  // Registers
  logic [7:0] ctrl_ff;
  logic [7:0] stat_ff;
  logic [7:0] counter_upper_ff;
  logic [7:0] counter_lower_ff;
  logic [7:0] compare_upper_ff;
  logic [7:0] compare_lower_ff;
  logic [7:0] clock_stop_ff;
  logic [7:0] staging_ff;
  logic [1:0] irq_req_ff;
  logic [1:0] irq_en_ff;
  logic       eq_hi_prev_ff;
  logic       eq_lo_prev_ff;
  logic       tog_hi_ff;
  logic       tog_lo_ff;
  logic [7:0] nxt_counter_upper;
  logic [7:0] nxt_counter_lower;
  logic [7:0] nxt_stat;
  logic [1:0] nxt_irq_req;

  // Prescaler and event ticks
  logic tick_div32;
  logic tick_div16;
  logic tick_div4;
  logic tick_sub4;
  logic event_tick;

  ctf_prescaler u_prescaler (
    .clk        (clk),
    .resetn     (resetn),
    .sub_clk    (sub_clk),
    .tick_div32 (tick_div32),
    .tick_div16 (tick_div16),
    .tick_div4  (tick_div4),
    .tick_sub4  (tick_sub4)
  );

  ctf_event_edge u_event_edge (
    .clk             (clk),
    .resetn          (resetn),
    .event_input_pin (event_input_pin),
    .edge_rising     (event_edge_rising),
    .event_tick      (event_tick)
  );

  // Tick chosen by a select field; system-clock sources stall when
  // the system clock is halted in the low power modes.
  function automatic logic sel_tick(input logic [2:0] sel,
                                    input logic       is_lower,
                                    input logic       lp);
    logic t;
    t = 1'b0;
    if (sel == SEL_DIV32) begin
      t = tick_div32 & ~lp;
    end else if (sel == SEL_DIV16) begin
      t = tick_div16 & ~lp;
    end else if (sel == SEL_DIV4) begin
      t = tick_div4 & ~lp;
    end else if (sel == SEL_SUB4) begin
      t = tick_sub4;
    end else if (is_lower && (sel[2:1] == SEL_EVENT[2:1])) begin
      t = event_tick & ~lp;
    end
    return t;
  endfunction

  // Mode and field decode
  logic       mode8;
  logic       running;
  logic [2:0] upper_clock_select;
  logic [2:0] lower_clock_select;

  assign upper_clock_select = ctrl_ff[CTRL_SEL_HI_MSB:CTRL_SEL_HI_LSB];
  assign lower_clock_select = ctrl_ff[CTRL_SEL_LO_MSB:CTRL_SEL_LO_LSB];
  assign mode8   = ctrl_ff[CTRL_SEL_HI_MSB];
  assign running = clock_stop_ff[CLK_STOP_BIT];

  // Count ticks and overflows
  logic tick_lo;
  logic tick_hi;
  logic ovf_lo;
  logic ovf_hi;

  // Process, not assign: the function reads the tick nets directly,
  // and a continuous assignment would not wake up when they change.
  always_comb begin
    tick_lo = running &
              sel_tick(lower_clock_select, 1'b1, low_power_mode);
  end
  assign ovf_lo  = tick_lo && (counter_lower_ff == BYTE_ONES);
  // Upper half follows lower overflow in 16-bit mode
  always_comb begin
    tick_hi = mode8 ? (running &
              sel_tick(upper_clock_select, 1'b0, low_power_mode))
                    : ovf_lo;
  end
  assign ovf_hi  = tick_hi && (counter_upper_ff == BYTE_ONES);

  // Compare: a match fires once on entering equality
  logic eq_hi;
  logic eq_lo;
  logic match_hi;
  logic match_lo;

  assign eq_hi = mode8 ? (counter_upper_ff == compare_upper_ff)
                       : ({counter_upper_ff, counter_lower_ff} ==
                          {compare_upper_ff, compare_lower_ff});
  assign eq_lo = mode8 && (counter_lower_ff == compare_lower_ff);
  assign match_hi = eq_hi & ~eq_hi_prev_ff;
  assign match_lo = eq_lo & ~eq_lo_prev_ff;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      eq_hi_prev_ff <= 1'b0;
      eq_lo_prev_ff <= 1'b0;
    end else begin
      eq_hi_prev_ff <= eq_hi;
      eq_lo_prev_ff <= eq_lo;
    end
  end

  // Register port decode
  logic wr_ctrl;
  logic wr_stat;
  logic wr_cnt_hi;
  logic wr_cnt_lo;
  logic wr_cmp_hi;
  logic wr_cmp_lo;
  logic rd_cnt_hi;
  logic rd_cmp_hi;

  assign wr_ctrl   = wr && (addr == ADDR_CTRL);
  assign wr_stat   = wr && (addr == ADDR_STAT);
  assign wr_cnt_hi = wr && (addr == ADDR_CNT_HI);
  assign wr_cnt_lo = wr && (addr == ADDR_CNT_LO);
  assign wr_cmp_hi = wr && (addr == ADDR_CMP_HI);
  assign wr_cmp_lo = wr && (addr == ADDR_CMP_LO);
  assign rd_cnt_hi = rd && (addr == ADDR_CNT_HI);
  assign rd_cmp_hi = rd && (addr == ADDR_CMP_HI);

  // Byte staging: upper write parks here, lower write commits both;
  // upper read captures the lower byte for the following lower read.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      staging_ff <= 8'h00;
    end else if (!mode8) begin
      if (wr_cnt_hi || wr_cmp_hi) begin
        staging_ff <= wdata;
      end else if (rd_cnt_hi) begin
        staging_ff <= counter_lower_ff;
      end else if (rd_cmp_hi) begin
        staging_ff <= compare_lower_ff;
      end
    end
  end

  // Control register: toggle presets take effect on write
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_ff <= RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_ff <= wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clock_stop_ff <= RST_CLK_STOP;
    end else if (wr && (addr == ADDR_CLK_STOP)) begin
      clock_stop_ff <= wdata;
    end
  end

  // Compare registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      compare_upper_ff <= RST_CMP;
      compare_lower_ff <= RST_CMP;
    end else begin
      if (mode8 && wr_cmp_hi) begin
        compare_upper_ff <= wdata;
      end else if (!mode8 && wr_cmp_lo) begin
        compare_upper_ff <= staging_ff;
      end
      if (wr_cmp_lo) begin
        compare_lower_ff <= wdata;
      end
    end
  end

  // Counter next values: CPU write, then match clear, then count
  always_comb begin
    nxt_counter_upper = counter_upper_ff;
    nxt_counter_lower = counter_lower_ff;
    if (!mode8) begin
      if (wr_cnt_lo) begin
        nxt_counter_upper = staging_ff;
        nxt_counter_lower = wdata;
      end else if (match_hi && stat_ff[STAT_CCLR_HI]) begin
        nxt_counter_upper = 8'h00;
        nxt_counter_lower = 8'h00;
      end else begin
        nxt_counter_lower = counter_lower_ff + {7'h00, tick_lo};
        nxt_counter_upper = counter_upper_ff + {7'h00, tick_hi};
      end
    end else begin
      if (wr_cnt_hi) begin
        nxt_counter_upper = wdata;
      end else if (match_hi && stat_ff[STAT_CCLR_HI]) begin
        nxt_counter_upper = 8'h00;
      end else begin
        nxt_counter_upper = counter_upper_ff + {7'h00, tick_hi};
      end
      if (wr_cnt_lo) begin
        nxt_counter_lower = wdata;
      end else if (match_lo && stat_ff[STAT_CCLR_LO]) begin
        nxt_counter_lower = 8'h00;
      end else begin
        nxt_counter_lower = counter_lower_ff + {7'h00, tick_lo};
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      counter_upper_ff <= RST_CNT;
      counter_lower_ff <= RST_CNT;
    end else begin
      counter_upper_ff <= nxt_counter_upper;
      counter_lower_ff <= nxt_counter_lower;
    end
  end

  // Status flags: written 0 clears, written 1 keeps; a set wins
  always_comb begin
    nxt_stat = stat_ff;
    if (wr_stat) begin
      nxt_stat = {wdata[7] & stat_ff[7], wdata[6] & stat_ff[6],
                  wdata[5:4],
                  wdata[3] & stat_ff[3], wdata[2] & stat_ff[2],
                  wdata[1:0]};
    end
    if (ovf_hi) begin
      nxt_stat[STAT_OVF_HI] = 1'b1;
    end
    if (match_hi) begin
      nxt_stat[STAT_CMF_HI] = 1'b1;
    end
    if (mode8 && ovf_lo) begin
      nxt_stat[STAT_OVF_LO] = 1'b1;
    end
    if (match_lo) begin
      nxt_stat[STAT_CMF_LO] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stat_ff <= RST_STAT;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  // Requests: compare match or enabled overflow per half
  always_comb begin
    nxt_irq_req = irq_req_ff;
    if (wr && (addr == ADDR_IRQ_REQ)) begin
      nxt_irq_req = irq_req_ff & wdata[1:0];
    end
    if (match_hi || (ovf_hi && stat_ff[STAT_OVIE_HI])) begin
      nxt_irq_req[IRQ_BIT_HI] = 1'b1;
    end
    if (match_lo || (mode8 && ovf_lo && stat_ff[STAT_OVIE_LO])) begin
      nxt_irq_req[IRQ_BIT_LO] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_req_ff <= 2'h0;
    end else begin
      irq_req_ff <= nxt_irq_req;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_en_ff <= 2'h0;
    end else if (wr && (addr == ADDR_IRQ_EN)) begin
      irq_en_ff <= wdata[1:0];
    end
  end

  assign irq_upper = irq_req_ff[IRQ_BIT_HI] & irq_en_ff[IRQ_BIT_HI];
  assign irq_lower = irq_req_ff[IRQ_BIT_LO] & irq_en_ff[IRQ_BIT_LO];

  // Toggle outputs: preset on control write, invert on match
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tog_hi_ff <= 1'b0;
      tog_lo_ff <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        tog_hi_ff <= wdata[CTRL_TOGGLE_HI];
      end else if (match_hi) begin
        tog_hi_ff <= ~tog_hi_ff;
      end
      if (wr_ctrl) begin
        tog_lo_ff <= wdata[CTRL_TOGGLE_LO];
      end else if (match_lo) begin
        tog_lo_ff <= ~tog_lo_ff;
      end
    end
  end

  assign upper_toggle_pin = tog_hi_ff;
  assign lower_toggle_pin = tog_lo_ff;

  // Read data, valid only in the cycle after the read strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 8'h00;
    end else if (rd) begin
      if (addr == ADDR_CTRL) begin
        rdata <= RD_WRITE_ONLY;
      end else if (addr == ADDR_STAT) begin
        rdata <= stat_ff;
      end else if (addr == ADDR_CNT_HI) begin
        rdata <= counter_upper_ff;
      end else if (addr == ADDR_CNT_LO) begin
        rdata <= mode8 ? counter_lower_ff : staging_ff;
      end else if (addr == ADDR_CMP_HI) begin
        rdata <= compare_upper_ff;
      end else if (addr == ADDR_CMP_LO) begin
        rdata <= mode8 ? compare_lower_ff : staging_ff;
      end else if (addr == ADDR_CLK_STOP) begin
        rdata <= clock_stop_ff;
      end else if (addr == ADDR_IRQ_REQ) begin
        rdata <= {6'h00, irq_req_ff};
      end else if (addr == ADDR_IRQ_EN) begin
        rdata <= {6'h00, irq_en_ff};
      end else begin
        rdata <= RD_UNMAPPED;
      end
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule

// ==== tb/ctf_timer_properties.sv ====
// Concurrent checks on the timer's register port, pins and interrupts
module ctf_timer_properties
  import ctf_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // Register port
  input wire logic [15:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  rdata,
  // Pins and interrupts
  input wire logic        upper_toggle_pin,
  input wire logic        lower_toggle_pin,
  input wire logic        irq_upper,
  input wire logic        irq_lower
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Shadows rebuilt from bus traffic, since the mode is not readable
  logic [7:0] ctrl_ff;
  logic [1:0] en_ff;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_ff <= RST_CTRL;
    end else if (wr && addr == ADDR_CTRL) begin
      ctrl_ff <= wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      en_ff <= 2'h0;
    end else if (wr && addr == ADDR_IRQ_EN) begin
      en_ff <= wdata[1:0];
    end
  end

  sequence s_cmp16_load;
    !ctrl_ff[CTRL_SEL_HI_MSB] && wr && addr == ADDR_CMP_HI
    ##1 wr && addr == ADDR_CMP_LO ##1 rd && addr == ADDR_CMP_HI;
  endsequence

  sequence s_cmp8_load;
    ctrl_ff[CTRL_SEL_HI_MSB] && wr && addr == ADDR_CMP_LO
    ##1 rd && addr == ADDR_CMP_LO;
  endsequence

  a_read_idle: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  a_ctrl_write_only: assert property (rd && addr == ADDR_CTRL
    |=> rdata == RD_WRITE_ONLY)
    else $error("control register read did not return all ones");
  a_unmapped_zero: assert property (rd && addr[15:8] != 8'hFF
    |=> rdata == RD_UNMAPPED)
    else $error("unmapped read returned data");
  a_preset_pins: assert property (wr && addr == ADDR_CTRL |=>
    upper_toggle_pin == $past(wdata[CTRL_TOGGLE_HI]) &&
    lower_toggle_pin == $past(wdata[CTRL_TOGGLE_LO]))
    else $error("toggle pins not loaded from control write");
  a_lower_quiet_wide: assert property (
    !ctrl_ff[CTRL_SEL_HI_MSB] && !(wr && addr == ADDR_CTRL)
    |=> $stable(lower_toggle_pin))
    else $error("lower toggle pin moved in 16-bit mode");
  a_irq_hi_gate: assert property (irq_upper |-> en_ff[1])
    else $error("upper interrupt without its enable");
  a_irq_lo_gate: assert property (irq_lower |-> en_ff[0])
    else $error("lower interrupt without its enable");
  a_cmp16_staged: assert property (
    s_cmp16_load |=> rdata == $past(wdata, 3))
    else $error("staged compare upper byte lost");
  a_cmp8_direct: assert property (
    s_cmp8_load |=> rdata == $past(wdata, 2))
    else $error("direct compare lower byte lost");
endmodule

bind ctf_timer ctf_timer_properties i_props (
  .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .upper_toggle_pin(upper_toggle_pin),
  .lower_toggle_pin(lower_toggle_pin), .irq_upper(irq_upper),
  .irq_lower(irq_lower));

// ==== tb/ctf_event_source.sv ====
// Stand-in for the external event source driving the timer's event pin
module ctf_event_source
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Burst request
  input  wire logic       start,
  input  wire logic [7:0] burst,
  input  wire logic       slow,
  // Event pin and status
  output logic            event_input_pin,
  output logic            busy
);
  // Each event is one high pulse; slow doubles both phases
  logic [7:0] left_ff;
  logic [1:0] ph_ff;

  assign busy = (left_ff != 8'h00);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      left_ff         <= 8'h00;
      ph_ff           <= 2'h0;
      event_input_pin <= 1'b0;
    end else if (start) begin
      left_ff <= burst;
      ph_ff   <= 2'h0;
    end else if (busy) begin
      ph_ff <= ph_ff + 2'h1;
      if (ph_ff == {slow, 1'b1}) begin
        ph_ff           <= 2'h0;
        event_input_pin <= !event_input_pin;
        if (event_input_pin) begin
          left_ff <= left_ff - 8'h01;
        end
      end
    end
  end
endmodule

// ==== tb/ctf_timer_bench.sv ====
// Self-checking bench of the cascadable compare timer
`define CHK(nm, e, g) \
  begin \
    compares++; \
    if ((g) !== (e)) begin \
      err_total++; \
      $display("Error %s expected %h seen %h", nm, e, g); \
    end \
  end

module ctf_timer_bench
  import ctf_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int WIN = 128;
  localparam logic [15:0] RA [8] = '{ADDR_STAT, ADDR_CNT_HI, ADDR_CNT_LO,
    ADDR_CMP_HI, ADDR_CMP_LO, ADDR_CTRL, ADDR_CLK_STOP, 16'h00B6};
  localparam logic [7:0] RV [8] = '{RST_STAT, RST_CNT, RST_CNT, RST_CMP,
    RST_CMP, RD_WRITE_ONLY, RST_CLK_STOP, RD_UNMAPPED};

  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  rdata;
  logic        sub_clk = 1'b0;
  logic        low_power_mode = 1'b0;
  logic        event_input_pin;
  logic        event_edge_rising = 1'b1;
  logic        upper_toggle_pin;
  logic        lower_toggle_pin;
  logic        irq_upper;
  logic        irq_lower;
  logic        start = 1'b0;
  logic        slow = 1'b0;
  logic [7:0]  burst = 8'h00;
  logic        busy;
  int          err_total = 0;
  int          compares = 0;
  int          seed = 58;

  always #25 clk = ~clk;
  // Subclock at an eighth of clk, edges on clk's falling edges
  always #200 sub_clk = ~sub_clk;

  ctf_timer i_dut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .sub_clk(sub_clk),
    .low_power_mode(low_power_mode), .event_input_pin(event_input_pin),
    .event_edge_rising(event_edge_rising),
    .upper_toggle_pin(upper_toggle_pin), .lower_toggle_pin(lower_toggle_pin),
    .irq_upper(irq_upper), .irq_lower(irq_lower));

  ctf_event_source i_src (.clk(clk), .resetn(resetn), .start(start),
    .burst(burst), .slow(slow), .event_input_pin(event_input_pin),
    .busy(busy));

  task automatic bus(input logic w, input logic r, input logic [15:0] a,
                     input logic [7:0] d);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask

  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 16'h0000, 8'h00);
  endtask

  task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
    bus(1'b0, 1'b1, a, 8'h00);
    #1 d = rdata;
  endtask

  task automatic chk_rd(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd_reg(a, d);
    `CHK($sformatf("read %h", a), e, d)
  endtask

  task automatic wr16(input logic [15:0] a, input logic [15:0] d);
    bus(1'b1, 1'b0, a, d[15:8]);
    bus(1'b1, 1'b0, a + 16'h0001, d[7:0]);
  endtask

  task automatic rd16(input logic [15:0] a, output logic [15:0] v);
    rd_reg(a, v[15:8]);
    rd_reg(a + 16'h0001, v[7:0]);
  endtask

  task automatic fire(input logic [7:0] n);
    start <= 1'b1;
    burst <= n;
    slow <= 1'($random(seed));
    idle(1);
    start <= 1'b0;
    idle(1);
    for (int k = 0; k < 400 && busy; k++) @(posedge clk);
    idle(6);
  endtask

  // Ticks expected in a window; low power keeps only subclock/4 alive
  function automatic int win_exp(input logic [2:0] s, input int m);
    int d;
    d = (s == SEL_DIV32 || s == SEL_SUB4) ? 32 : (s == SEL_DIV16) ? 16 : 4;
    if (m == 2 || (m == 1 && s != SEL_SUB4)) return 0;
    return WIN / d;
  endfunction

  task automatic chk_win(input int ex, input logic [7:0] got);
    logic ok;
    ok = (ex == 0) ? (got == 8'h00) : (got >= ex - 1 && got <= ex + 1);
    `CHK("window count", 1'b1, ok)
  endtask

  task automatic tally_and_finish();
    if (err_total == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end

  initial begin
    logic [7:0]  b;
    logic [15:0] v;
    logic [2:0]  s;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    idle(1);
    for (int i = 0; i < 8; i++) chk_rd(RA[i], RV[i]);
    `CHK("pins", 4'h0, {upper_toggle_pin, lower_toggle_pin, irq_upper, irq_lower})
    for (int e = 0; e < 2; e++) begin
      event_edge_rising <= e[0];
      wr16(ADDR_CNT_HI, 16'h00FD);
      b = 8'h02 + {5'h00, 3'($random(seed))};
      fire(b);
      rd16(ADDR_CNT_HI, v);
      `CHK("count16", 16'h00FD + {8'h00, b}, v)
    end
    wr16(ADDR_CMP_HI, 16'h1234);
    bus(1'b1, 1'b0, ADDR_STAT, 8'h20);
    wr16(ADDR_CNT_HI, 16'hFFFF);
    fire(8'h01);
    chk_rd(ADDR_STAT, 8'hA0);
    `CHK("irq masked", 1'b0, irq_upper)
    chk_rd(ADDR_IRQ_REQ, 8'h02);
    bus(1'b1, 1'b0, ADDR_IRQ_EN, 8'h02);
    idle(1);
    #1 `CHK("irq upper", 1'b1, irq_upper)
    bus(1'b1, 1'b0, ADDR_STAT, 8'hE0);
    chk_rd(ADDR_STAT, 8'hA0);
    bus(1'b1, 1'b0, ADDR_STAT, 8'h20);
    bus(1'b1, 1'b0, ADDR_IRQ_REQ, 8'h00);
    chk_rd(ADDR_STAT, 8'h20);
    `CHK("irq cleared", 1'b0, irq_upper)
    bus(1'b1, 1'b0, ADDR_CTRL, 8'h80);
    bus(1'b1, 1'b0, ADDR_STAT, 8'h10);
    wr16(ADDR_CMP_HI, 16'h0003);
    rd16(ADDR_CMP_HI, v);
    `CHK("cmp16", 16'h0003, v)
    wr16(ADDR_CNT_HI, 16'h0000);
    `CHK("preset", 2'b10, {upper_toggle_pin, lower_toggle_pin})
    fire(8'h05);
    rd16(ADDR_CNT_HI, v);
    `CHK("cleared16", 16'h0002, v)
    `CHK("toggled", 3'b001, {upper_toggle_pin, lower_toggle_pin, irq_upper})
    chk_rd(ADDR_STAT, 8'h50);
    bus(1'b1, 1'b0, ADDR_STAT, 8'h00);
    wr16(ADDR_CMP_HI, 16'hFFFF);
    for (int m = 0; m < 3; m++) begin
      for (int k = 4; k < 8; k++) begin
        s = 3'(k);
        low_power_mode <= 1'(m == 1);
        bus(1'b1, 1'b0, ADDR_CLK_STOP, (m == 2) ? 8'hFB : 8'hFF);
        bus(1'b1, 1'b0, ADDR_CTRL, {1'b0, s, 1'b0, s});
        bus(1'b1, 1'b0, ADDR_CNT_HI, 8'h00);
        bus(1'b1, 1'b0, ADDR_CNT_LO, 8'h00);
        idle(WIN - 2);
        rd_reg(ADDR_CNT_HI, b);
        chk_win(win_exp(s, m), b);
        rd_reg(ADDR_CNT_LO, b);
        chk_win(win_exp(s, m), b);
      end
    end
    low_power_mode <= 1'b0;
    bus(1'b1, 1'b0, ADDR_CLK_STOP, 8'hFF);
    bus(1'b1, 1'b0, ADDR_CTRL, 8'hC6);
    b = 8'h10 + {3'h0, 5'($random(seed))};
    bus(1'b1, 1'b0, ADDR_CMP_LO, b);
    chk_rd(ADDR_CMP_LO, b);
    bus(1'b1, 1'b0, ADDR_CNT_LO, 8'hFC);
    bus(1'b1, 1'b0, ADDR_STAT, 8'h02);
    bus(1'b1, 1'b0, ADDR_IRQ_REQ, 8'h00);
    bus(1'b1, 1'b0, ADDR_IRQ_EN, 8'h01);
    idle(4 * (int'(b) + 8));
    chk_rd(ADDR_STAT, 8'h0E);
    `CHK("pins8", 4'hD, {upper_toggle_pin, lower_toggle_pin, irq_upper, irq_lower})
    bus(1'b1, 1'b0, ADDR_STAT, 8'h01);
    idle(1200);
    rd_reg(ADDR_CNT_LO, v[7:0]);
    `CHK("clear8", 1'b1, v[7:0] <= b)
    idle(1);
    tally_and_finish();
  end
endmodule
